// ==== common/trx_pkg.sv ====
// Purpose: shared constants and types for the timer readout transfer block
// Assumes: 10-bit instruction words, 4-bit data path, 8-bit timers
// Notes: opcodes are full instruction words, no operand field
package trx_pkg;
	localparam int NIB_W = 4;
	localparam int TMR_W = 8;
	localparam int OPC_W = 10;
	localparam int NUM_TMR = 3;

	// instruction words
	localparam logic [OPC_W-1:0] OPC_COPY_B_TO_A = 10'h01e;
	localparam logic [OPC_W-1:0] OPC_READ_TIMER_ONE = 10'h270;
	localparam logic [OPC_W-1:0] OPC_READ_TIMER_TWO = 10'h271;
	localparam logic [OPC_W-1:0] OPC_READ_TIMER_THREE = 10'h272;

	// cost of every instruction handled here
	localparam logic [1:0] OP_WORDS = 2'h1;
	localparam logic [1:0] OP_CYCLES = 2'h1;

	// reset values
	localparam logic [NIB_W-1:0] NIB_RST = 4'h0;

	typedef enum logic [2:0] {
		TRX_OP_NONE,
		TRX_OP_COPY,
		TRX_OP_TMR1,
		TRX_OP_TMR2,
		TRX_OP_TMR3
	} trx_op_t;

	typedef struct packed {
		trx_op_t op;
		logic done;
		logic acc_we;
		logic [NIB_W-1:0] acc_wdata;
		logic aux_we;
		logic [NIB_W-1:0] aux_wdata;
		logic carry_we;
		logic skip_next;
		logic [1:0] words;
		logic [1:0] cycles;
	} trx_state_t;
endpackage

// ==== design/trx_nib_split.sv ====
// Purpose: split one timer value into its upper and lower nibble
// Assumes: timer width is exactly two nibbles
// Notes: pure wiring, one instance per timer
`timescale 1ns/1ps
module trx_nib_split #(
	parameter int NIB_W = 4
) (
	// timer value in
	input wire logic [2*NIB_W-1:0] value,
	// nibbles out
	output logic [NIB_W-1:0] hi,
	output logic [NIB_W-1:0] lo
);
	// elaboration check
	if (NIB_W < 1) begin
		$error("trx_nib_split: NIB_W must be at least 1");
	end

	assign hi = value[2*NIB_W-1:NIB_W];
	assign lo = value[NIB_W-1:0];
endmodule

// ==== design/trx_transfer.sv ====
// Contract
// RQ1: copy opcode loads accumulator from auxiliary register
// RQ2: timer one: upper nibble aux, lower accumulator
// RQ3: timer two: upper nibble aux, lower accumulator
// RQ4: timer three: upper nibble aux, lower accumulator
// RQ5: one word, one cycle, carry kept, no skip
//
// Purpose: execute the register copy and timer readout transfers
// Assumes: decoder presents one instruction word per cycle with a valid strobe;
//   register and timer values are sampled in the cycle the word is taken
// Notes: write-backs appear the cycle after the instruction is taken;
//   strobes, done and op_done last one cycle, data and cost hold until the
//   next handled instruction writing them; carry and skip requests stay low throughout
`timescale 1ns/1ps
module trx_transfer
	import trx_pkg::*;
#(
	parameter int DATA_W = trx_pkg::NIB_W,
	parameter int TIMER_W = trx_pkg::TMR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// instruction from decoder
	input wire logic instr_valid,
	input wire logic [trx_pkg::OPC_W-1:0] instr_word,
	// current register file and timer values
	input wire logic [trx_pkg::NIB_W-1:0] aux_rdata,
	input wire logic [trx_pkg::TMR_W-1:0] timer_one,
	input wire logic [trx_pkg::TMR_W-1:0] timer_two,
	input wire logic [trx_pkg::TMR_W-1:0] timer_three,
	// write-back to register file
	output logic acc_we,
	output logic [trx_pkg::NIB_W-1:0] acc_wdata,
	output logic aux_we,
	output logic [trx_pkg::NIB_W-1:0] aux_wdata,
	// carry and skip requests
	output logic carry_flag_we,
	output logic skip_next,
	// completion and instruction cost
	output logic done,
	output trx_pkg::trx_op_t op_done,
	output logic [1:0] op_words,
	output logic [1:0] op_cycles
);
	import trx_pkg::*;

	// elaboration checks: the datapath is two nibbles per timer
	if (DATA_W != NIB_W) begin
		$error("trx_transfer: DATA_W must equal the package nibble width");
	end
	if (TIMER_W != 2 * DATA_W) begin
		$error("trx_transfer: TIMER_W must be two nibbles");
	end
	if (TIMER_W != TMR_W) begin
		$error("trx_transfer: TIMER_W must equal the package timer width");
	end

	// one split instance is wired per timer below
	if (NUM_TMR != 3) begin
		$error("trx_transfer: exactly three timers are wired");
	end

	// a shared word would decode to one op and silently lose the other
	if (OPC_COPY_B_TO_A == OPC_READ_TIMER_ONE || OPC_COPY_B_TO_A == OPC_READ_TIMER_TWO ||
		OPC_COPY_B_TO_A == OPC_READ_TIMER_THREE || OPC_READ_TIMER_ONE == OPC_READ_TIMER_TWO ||
		OPC_READ_TIMER_ONE == OPC_READ_TIMER_THREE ||
		OPC_READ_TIMER_TWO == OPC_READ_TIMER_THREE) begin
		$error("trx_transfer: instruction words must be distinct");
	end

	// the cost outputs double as a completion marker, so zero is refused
	if (OP_WORDS == 2'h0 || OP_CYCLES == 2'h0) begin
		$error("trx_transfer: instruction cost must be nonzero");
	end

	// indexed per timer so one split module serves all three
	logic [NIB_W-1:0] tmr_hi [NUM_TMR];
	logic [NIB_W-1:0] tmr_lo [NUM_TMR];
	logic [TMR_W-1:0] tmr_val [NUM_TMR];

	assign tmr_val[0] = timer_one;
	assign tmr_val[1] = timer_two;
	assign tmr_val[2] = timer_three;

	// both nibbles come from the same sample, so a counting timer never tears
	trx_nib_split #(.NIB_W(NIB_W)) u_split_one (
		.value(tmr_val[0]),
		.hi(tmr_hi[0]),
		.lo(tmr_lo[0])
	);

	trx_nib_split #(.NIB_W(NIB_W)) u_split_two (
		.value(tmr_val[1]),
		.hi(tmr_hi[1]),
		.lo(tmr_lo[1])
	);

	trx_nib_split #(.NIB_W(NIB_W)) u_split_three (
		.value(tmr_val[2]),
		.hi(tmr_hi[2]),
		.lo(tmr_lo[2])
	);

	// all registered state lives in one struct
	trx_state_t st_q;
	trx_state_t st_d;

	// op decoded from the word on the bus this cycle
	trx_op_t dec_op;

	always_comb begin
		dec_op = TRX_OP_NONE;
		if (instr_valid) begin
			// only the four exact words are taken; neighbours fall through
			case (instr_word)
				OPC_COPY_B_TO_A: begin
					dec_op = TRX_OP_COPY;
				end
				OPC_READ_TIMER_ONE: begin
					dec_op = TRX_OP_TMR1;
				end
				OPC_READ_TIMER_TWO: begin
					dec_op = TRX_OP_TMR2;
				end
				OPC_READ_TIMER_THREE: begin
					dec_op = TRX_OP_TMR3;
				end
				default: begin
					dec_op = TRX_OP_NONE;
				end
			endcase
		end
	end

	always_comb begin
		st_d = st_q;
		// strobes last one cycle; data holds until the next handled instruction that writes it
		st_d.op = dec_op;
		st_d.done = 1'b0;
		st_d.acc_we = 1'b0;
		st_d.aux_we = 1'b0;
		// never touches carry and never skips
		st_d.carry_we = 1'b0; // RQ5
		st_d.skip_next = 1'b0; // RQ5

		// a handled op writes its nibbles and marks completion
		case (dec_op)
			TRX_OP_COPY: begin
				st_d.done = 1'b1;
				// copy leaves the auxiliary side untouched
				st_d.acc_we = 1'b1; // RQ1
				st_d.acc_wdata = aux_rdata; // RQ1
			end

			TRX_OP_TMR1: begin
				st_d.done = 1'b1;
				st_d.aux_we = 1'b1; // RQ2
				st_d.aux_wdata = tmr_hi[0]; // RQ2
				st_d.acc_we = 1'b1; // RQ2
				st_d.acc_wdata = tmr_lo[0]; // RQ2
			end

			TRX_OP_TMR2: begin
				st_d.done = 1'b1;
				st_d.aux_we = 1'b1; // RQ3
				st_d.aux_wdata = tmr_hi[1]; // RQ3
				st_d.acc_we = 1'b1; // RQ3
				st_d.acc_wdata = tmr_lo[1]; // RQ3
			end

			TRX_OP_TMR3: begin
				st_d.done = 1'b1;
				st_d.aux_we = 1'b1; // RQ4
				st_d.aux_wdata = tmr_hi[2]; // RQ4
				st_d.acc_we = 1'b1; // RQ4
				st_d.acc_wdata = tmr_lo[2]; // RQ4
			end

			default: begin
				st_d.done = 1'b0;
			end
		endcase

		// cost holds its last value while idle
		if (st_d.done) begin
			st_d.words = OP_WORDS; // RQ5
			st_d.cycles = OP_CYCLES; // RQ5
		end
	end

	// synchronous reset; every field gets a constant
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q.op <= TRX_OP_NONE;
			st_q.done <= 1'b0;
			st_q.acc_we <= 1'b0;
			st_q.acc_wdata <= NIB_RST;
			st_q.aux_we <= 1'b0;
			st_q.aux_wdata <= NIB_RST;
			st_q.carry_we <= 1'b0;
			st_q.skip_next <= 1'b0;
			st_q.words <= 2'h0;
			st_q.cycles <= 2'h0;
		end else begin
			st_q <= st_d;
		end
	end

	// write-back straight from the registered struct
	assign acc_we = st_q.acc_we;
	assign acc_wdata = st_q.acc_wdata;
	assign aux_we = st_q.aux_we;
	assign aux_wdata = st_q.aux_wdata;

	// flag, skip and completion
	assign carry_flag_we = st_q.carry_we;
	assign skip_next = st_q.skip_next;
	assign done = st_q.done;
	assign op_done = st_q.op;
	assign op_words = st_q.words;
	assign op_cycles = st_q.cycles;
endmodule

// ==== verification/trx_transfer_properties.sv ====
// Purpose: port-level checks of the transfer write-backs
// Assumes: one-cycle registered answer after each taken instruction
// Notes: timer checks compare both nibbles in one go
`timescale 1ns/1ps
module trx_transfer_properties
	import trx_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [trx_pkg::OPC_W-1:0] instr_word,
	input wire logic [trx_pkg::NIB_W-1:0] aux_rdata,
	input wire logic [trx_pkg::TMR_W-1:0] timer_one,
	input wire logic [trx_pkg::TMR_W-1:0] timer_two,
	input wire logic [trx_pkg::TMR_W-1:0] timer_three,
	input wire logic acc_we,
	input wire logic [trx_pkg::NIB_W-1:0] acc_wdata,
	input wire logic aux_we,
	input wire logic [trx_pkg::NIB_W-1:0] aux_wdata,
	input wire logic carry_flag_we,
	input wire logic skip_next,
	input wire logic done,
	input trx_pkg::trx_op_t op_done,
	input wire logic [1:0] op_words,
	input wire logic [1:0] op_cycles
);
	import trx_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_copy_load: assert property (instr_valid && instr_word == OPC_COPY_B_TO_A |=>
		acc_we && !aux_we && acc_wdata == $past(aux_rdata)) else $error("copy wrong");
	a_timer_one: assert property (instr_valid && instr_word == OPC_READ_TIMER_ONE |=>
		acc_we && aux_we && {aux_wdata, acc_wdata} == $past(timer_one)) else $error("t1 wrong");
	a_timer_two: assert property (instr_valid && instr_word == OPC_READ_TIMER_TWO |=>
		acc_we && aux_we && {aux_wdata, acc_wdata} == $past(timer_two)) else $error("t2 wrong");
	a_timer_three: assert property (instr_valid && instr_word == OPC_READ_TIMER_THREE |=>
		acc_we && aux_we && {aux_wdata, acc_wdata} == $past(timer_three)) else $error("t3 wrong");
	a_flags_kept: assert property (!carry_flag_we && !skip_next) else $error("flag or skip");
	a_op_cost: assert property (done |-> op_words == OP_WORDS && op_cycles == OP_CYCLES)
		else $error("cost wrong");
	c_copy: cover property (done && op_done == TRX_OP_COPY);
	c_tmr3: cover property (done && op_done == TRX_OP_TMR3);
	c_b2b: cover property (done ##1 done);
endmodule
bind trx_transfer trx_transfer_properties u_props (.*);

// ==== verification/trx_transfer_tb.sv ====
// Purpose: random and corner stimulus with a reference of the write-backs
// Assumes: answer one cycle after the instruction
// Notes: opcode 273 is an unhandled neighbour and must be ignored
`timescale 1ns/1ps
module trx_transfer_tb;
	import trx_pkg::*;
	logic clk = 1'h0, sys_rst = 1'h1, instr_valid = 1'h0;
	logic [OPC_W-1:0] instr_word = '0;
	logic [NIB_W-1:0] aux_rdata = '0, acc_wdata, aux_wdata, e_acc = '0, e_aux = '0;
	logic [TMR_W-1:0] timer_one = '0, timer_two = '0, timer_three = '0, t;
	logic acc_we, aux_we, carry_flag_we, skip_next, done, hit = 1'h0, tw = 1'h0;
	trx_op_t op_done, e_op = TRX_OP_NONE;
	logic [1:0] op_words, op_cycles, e_w = 2'h0;
	int failures = 0, checks = 0, cycles = 0, k;
	logic [OPC_W-1:0] opc [5] = '{OPC_COPY_B_TO_A, OPC_READ_TIMER_ONE,
		OPC_READ_TIMER_TWO, OPC_READ_TIMER_THREE, 10'h273};
	trx_transfer u_dut (
		.clk(clk),
		.sys_rst(sys_rst),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.aux_rdata(aux_rdata),
		.timer_one(timer_one),
		.timer_two(timer_two),
		.timer_three(timer_three),
		.acc_we(acc_we),
		.acc_wdata(acc_wdata),
		.aux_we(aux_we),
		.aux_wdata(aux_wdata),
		.carry_flag_we(carry_flag_we),
		.skip_next(skip_next),
		.done(done),
		.op_done(op_done),
		.op_words(op_words),
		.op_cycles(op_cycles)
	);
	// which timer an opcode index reads
	function automatic logic [TMR_W-1:0] timer_of(int sel, logic [TMR_W-1:0] a, b, c);
		return (sel == 1) ? a : (sel == 2) ? b : c;
	endfunction
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic check(string n, logic [7:0] s, logic [7:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h02a3));
		repeat (5) @(negedge clk);
		sys_rst = 1'h0;
		// first ten back to back through every opcode, then random
		for (int i = 0; i < 600; i++) begin
			@(negedge clk);
			check("done", done, hit);
			check("acc_we", acc_we, hit);
			check("aux_we", aux_we, tw);
			check("acc", acc_wdata, e_acc);
			check("aux", aux_wdata, e_aux);
			check("op", op_done, e_op);
			check("cost", {op_words, op_cycles}, {e_w, e_w});
			check("flags", {carry_flag_we, skip_next}, 8'h00);
			k = (i < 10) ? i % 5 : $urandom_range(4);
			instr_valid = (i != 300) && ((i < 10) || ($urandom_range(3) != 0));
			instr_word = opc[k];
			aux_rdata = NIB_W'($urandom);
			timer_one = TMR_W'($urandom);
			timer_two = TMR_W'($urandom);
			timer_three = TMR_W'($urandom);
			t = timer_of(k, timer_one, timer_two, timer_three);
			hit = instr_valid && k < 4;
			tw = hit && k > 0;
			e_op = hit ? trx_op_t'(k + 1) : TRX_OP_NONE;
			if (hit) begin
				e_w = 2'h1;
				e_acc = (k == 0) ? aux_rdata : t[3:0];
			end
			if (tw) e_aux = t[7:4];
			if (i == 300) begin
				// mid-run reset: held data and cost must return to reset values
				sys_rst = 1'h1;
				e_acc = NIB_RST;
				e_aux = NIB_RST;
				e_w = 2'h0;
				repeat (2) @(negedge clk);
				sys_rst = 1'h0;
			end
		end
		print_verdict();
	end
endmodule
